// file: core/pmm_pkg.sv
// Package: constants, types and register map of the program memory map partition block
// Summary of operation
// - Part identifier holds 12-bit read-only id
// - Part identifier bits 13:12 read one
// - Revision bit 13 reads one, 12 zero
// - Revision bits 11:6 hold major revision
// - Revision bits 5:0 hold minor revision
// - Program counter is 15 bits wide
// - Addresses above memory size wrap around
// - Reset vector 0000h, interrupt vector 0004h
// - Pointer high bit 7 selects program memory
// - Indirect read returns low eight bits
// - Indirect writes never modify program memory
// - Program memory indirect read adds one cycle
// - Fetch and data use separate buses
// - Both partitions disabled: all application block
// - Boot block starts at zero, size selected
// - Storage area enabled by active-low bit
// - Storage area is last 128 words
// - Fetch from storage area flagged invalid
// - Boot enable bit is active low
// - Oversized boot selection clamps to half memory
// - Boot size changeable only while boot disabled
// - Protected write leaves memory, sets error flag
package pmm_pkg;
    // ************************************************************
    // Sizes and vectors
    // ************************************************************
    localparam int PC_W = 15;
    localparam int WORD_W = 14;
    localparam int MEM_AW = 13;
    localparam logic [PC_W-1:0] MASK_SMALL = 15'h0FFF;
    localparam logic [PC_W-1:0] MASK_LARGE = 15'h1FFF;
    localparam logic [PC_W-1:0] RESET_VECTOR = 15'h0000;
    localparam logic [PC_W-1:0] INT_VECTOR = 15'h0004;
    localparam logic [PC_W-1:0] STORAGE_WORDS = 15'h0080;
    localparam logic [7:0] PTR_PROG_BIT = 8'h80;
    // ************************************************************
    // Register map and identity fields
    // ************************************************************
    localparam logic [15:0] ADDR_REVISION = 16'h8005;
    localparam logic [15:0] ADDR_PART_ID = 16'h8006;
    localparam logic [15:0] ADDR_CONFIG = 16'h0010;
    localparam logic [15:0] ADDR_STATUS = 16'h0011;
    localparam logic [1:0] PART_RSVD = 2'h3;
    localparam logic [1:0] REV_RSVD = 2'h2;
    localparam logic [2:0] BOOT_SIZE_RESET = 3'h7;
    // Boot block end addresses per size code 0..7
    localparam logic [PC_W-1:0] BB_END [8] = '{15'h3FFF, 15'h3FFF, 15'h3FFF, 15'h1FFF,
        15'h0FFF, 15'h07FF, 15'h03FF, 15'h01FF};

    typedef struct packed {
        logic boot_partition_enable_n;
        logic storage_area_enable_n;
        logic [2:0] boot_size_select;
        logic wrt_app_n;
        logic wrt_boot_n;
        logic wrt_storage_n;
    } pmm_cfg_t;

    typedef struct packed {
        logic [PC_W-1:0] fetch_addr;
        logic fetch_invalid;
        logic [1:0] fetch_region;
        logic [7:0] ind_data;
        logic ind_valid;
        logic ind_busy;
        logic ind_pending;
        logic [PC_W-1:0] ind_addr;
        logic write_error_flag;
        logic nvm_wr_ok;
        logic [15:0] rd_data;
        pmm_cfg_t cfg;
    } pmm_state_t;
endpackage

// file: core/pmm_map.sv
// Module: program memory address decode, partitioning and identification registers
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module pmm_map #(
    parameter logic [11:0] PART_ID = 12'hA5C, // arbitrary value
    parameter logic [5:0] MAJOR_REV = 6'h01,   // arbitrary value
    parameter logic [5:0] MINOR_REV = 6'h00,   // arbitrary value
    parameter bit LARGE_MEM = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    input wire logic [pmm_pkg::PC_W-1:0] i_fetch_pc,
    input wire logic i_fetch_req,
    input wire logic i_take_reset,
    input wire logic i_take_int,
    output logic [pmm_pkg::PC_W-1:0] o_fetch_addr,
    output logic o_fetch_invalid,
    output logic [1:0] o_fetch_region,
    input wire logic [7:0] i_pointer_high_byte,
    input wire logic [7:0] i_pointer_low_byte,
    input wire logic i_indirect_move_read,
    input wire logic i_indirect_write,
    input wire logic [pmm_pkg::WORD_W-1:0] i_mem_rdata,
    output logic [pmm_pkg::PC_W-1:0] o_mem_addr,
    output logic [7:0] o_indirect_data_port,
    output logic o_ind_valid,
    output logic o_ind_busy,
    input wire logic [pmm_pkg::PC_W-1:0] i_nvm_addr,
    input wire logic i_nvm_wr,
    output logic o_nvm_wr_ok,
    output logic o_write_error_flag
);
    pmm_pkg::pmm_state_t st, next_st;
    logic [pmm_pkg::PC_W-1:0] mask;
    logic [pmm_pkg::PC_W-1:0] boot_end;
    logic [pmm_pkg::PC_W-1:0] storage_start;
    logic [pmm_pkg::PC_W-1:0] ind_ptr;

    // ************************************************************
    // Partition decode
    // ************************************************************
    function automatic logic [1:0] region(input logic [pmm_pkg::PC_W-1:0] a,
        input pmm_pkg::pmm_cfg_t c, input logic [pmm_pkg::PC_W-1:0] be,
        input logic [pmm_pkg::PC_W-1:0] ss);
        logic [1:0] r;
        r = 2'h0;
        if (!c.boot_partition_enable_n && a <= be)
            r = 2'h1;
        else if (!c.storage_area_enable_n && a >= ss)
            r = 2'h2;
        return r;
    endfunction

    always_comb
    begin
        mask = LARGE_MEM ? pmm_pkg::MASK_LARGE : pmm_pkg::MASK_SMALL;
        boot_end = pmm_pkg::BB_END[st.cfg.boot_size_select];
        if (boot_end > (mask >> 1))
            boot_end = mask >> 1;
        storage_start = mask - pmm_pkg::STORAGE_WORDS + 15'h0001;
        ind_ptr = {i_pointer_high_byte[6:0], i_pointer_low_byte} & mask;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [pmm_pkg::PC_W-1:0] fa;
        logic [1:0] wr_reg;
        fa = '0;
        wr_reg = '0;
        next_st = st;
        next_st.ind_valid = 1'b0;
        next_st.nvm_wr_ok = 1'b0;
        next_st.rd_data = '0;
        // Fetch path runs beside the data path every cycle
        if (i_take_reset)
            fa = pmm_pkg::RESET_VECTOR;
        else if (i_take_int)
            fa = pmm_pkg::INT_VECTOR;
        else
            fa = i_fetch_pc & mask;
        next_st.fetch_addr = fa;
        next_st.fetch_region = region(fa, st.cfg, boot_end, storage_start);
        next_st.fetch_invalid = i_fetch_req && !i_take_reset && !i_take_int
            && next_st.fetch_region == 2'h2;
        // Program memory indirect read: address cycle then data cycle
        if (st.ind_pending)
        begin
            next_st.ind_data = i_mem_rdata[7:0];
            next_st.ind_valid = 1'b1;
            next_st.ind_pending = 1'b0;
            next_st.ind_busy = 1'b0;
        end
        else if (i_indirect_move_read && (i_pointer_high_byte & pmm_pkg::PTR_PROG_BIT) != 8'h00)
        begin
            next_st.ind_addr = ind_ptr;
            next_st.ind_pending = 1'b1;
            next_st.ind_busy = 1'b1;
        end
        // Indirect writes aimed at program memory are dropped: no write path exists.
        // Error flag clear comes first so that a protected write in the same cycle wins
        if (i_reg_wr && i_reg_addr == pmm_pkg::ADDR_STATUS && i_reg_wdata[0])
            next_st.write_error_flag = 1'b0;
        // Nonvolatile write protection
        if (i_nvm_wr)
        begin
            wr_reg = region(i_nvm_addr & mask, st.cfg, boot_end, storage_start);
            if ((wr_reg == 2'h0 && !st.cfg.wrt_app_n) || (wr_reg == 2'h1 && !st.cfg.wrt_boot_n)
                || (wr_reg == 2'h2 && !st.cfg.wrt_storage_n))
                next_st.write_error_flag = 1'b1;
            else
                next_st.nvm_wr_ok = 1'b1;
        end
        // Register writes
        if (i_reg_wr && i_reg_addr == pmm_pkg::ADDR_CONFIG)
        begin
            next_st.cfg.boot_partition_enable_n = i_reg_wdata[3];
            next_st.cfg.storage_area_enable_n = i_reg_wdata[4];
            next_st.cfg.wrt_app_n = i_reg_wdata[7];
            next_st.cfg.wrt_boot_n = i_reg_wdata[8];
            next_st.cfg.wrt_storage_n = i_reg_wdata[11];
            if (st.cfg.boot_partition_enable_n)
                next_st.cfg.boot_size_select = i_reg_wdata[2:0];
        end
        // Register reads
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                pmm_pkg::ADDR_PART_ID:
                    next_st.rd_data = {2'h0, pmm_pkg::PART_RSVD, PART_ID};
                pmm_pkg::ADDR_REVISION:
                    next_st.rd_data = {2'h0, pmm_pkg::REV_RSVD, MAJOR_REV, MINOR_REV};
                pmm_pkg::ADDR_CONFIG:
                    next_st.rd_data = {4'h0, st.cfg.wrt_storage_n, 2'h0, st.cfg.wrt_boot_n,
                        st.cfg.wrt_app_n, 2'h0, st.cfg.storage_area_enable_n,
                        st.cfg.boot_partition_enable_n, st.cfg.boot_size_select};
                pmm_pkg::ADDR_STATUS:
                    next_st.rd_data = {12'h000, st.ind_busy, st.fetch_region, st.write_error_flag};
                default:
                    next_st.rd_data = '0;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            st <= '0;
            st.fetch_addr <= pmm_pkg::RESET_VECTOR;
            st.cfg.boot_partition_enable_n <= 1'b1;
            st.cfg.storage_area_enable_n <= 1'b1;
            st.cfg.boot_size_select <= pmm_pkg::BOOT_SIZE_RESET;
            st.cfg.wrt_app_n <= 1'b1;
            st.cfg.wrt_boot_n <= 1'b1;
            st.cfg.wrt_storage_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_reg_rdata = st.rd_data;
    assign o_fetch_addr = st.fetch_addr;
    assign o_fetch_invalid = st.fetch_invalid;
    assign o_fetch_region = st.fetch_region;
    assign o_mem_addr = st.ind_addr;
    assign o_indirect_data_port = st.ind_data;
    assign o_ind_valid = st.ind_valid;
    assign o_ind_busy = st.ind_busy;
    assign o_nvm_wr_ok = st.nvm_wr_ok;
    assign o_write_error_flag = st.write_error_flag;
endmodule

// file: test/pmm_map_monitor.sv
// Checker: concurrent assertions on the program memory map ports
`timescale 1ns/1ps
module pmm_map_monitor #(
    parameter logic [11:0] PART_ID = 12'hA5C,
    parameter logic [5:0] MAJOR_REV = 6'h01,
    parameter logic [5:0] MINOR_REV = 6'h00,
    parameter bit LARGE_MEM = 1'b1
) (
    input logic i_clk_sys, input logic i_reset,
    input logic [15:0] i_reg_addr, input logic i_reg_rd, input logic [15:0] o_reg_rdata,
    input logic [14:0] i_fetch_pc, input logic i_fetch_req,
    input logic i_take_reset, input logic i_take_int,
    input logic [14:0] o_fetch_addr, input logic o_fetch_invalid, input logic [1:0] o_fetch_region,
    input logic [7:0] i_pointer_high_byte, input logic [7:0] i_pointer_low_byte,
    input logic i_indirect_move_read, input logic [13:0] i_mem_rdata, input logic [14:0] o_mem_addr,
    input logic [7:0] o_indirect_data_port, input logic o_ind_valid, input logic o_ind_busy,
    input logic i_nvm_wr, input logic o_nvm_wr_ok, input logic o_write_error_flag
);
    localparam logic [14:0] MASK = LARGE_MEM ? pmm_pkg::MASK_LARGE : pmm_pkg::MASK_SMALL;
    logic vec;
    logic [14:0] ptr;
    logic [7:0] mem_lo;
    assign vec = i_take_reset || i_take_int;
    assign ptr = {i_pointer_high_byte[6:0], i_pointer_low_byte};
    assign mem_lo = i_mem_rdata[7:0];
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    AST_FETCH_WRAP: assert property (i_fetch_req && !vec |=>
        o_fetch_addr == ($past(i_fetch_pc) & MASK)) else $error("fetch address not masked");
    AST_RESET_VEC: assert property (i_fetch_req && i_take_reset |=>
        o_fetch_addr == pmm_pkg::RESET_VECTOR) else $error("reset vector wrong");
    AST_INT_VEC: assert property (i_fetch_req && i_take_int && !i_take_reset |=>
        o_fetch_addr == pmm_pkg::INT_VECTOR) else $error("interrupt vector wrong");
    AST_IND_EXTRA: assert property (i_indirect_move_read && i_pointer_high_byte[7]
        && !o_ind_busy && !o_ind_valid |=> (o_ind_busy && !o_ind_valid) ##1
        (o_ind_valid && !o_ind_busy)) else $error("indirect read timing wrong");
    AST_IND_ADDR: assert property ($rose(o_ind_busy) |->
        o_mem_addr == ($past(ptr) & MASK)) else $error("indirect address wrong");
    AST_IND_LOW: assert property (o_ind_valid |->
        o_indirect_data_port == $past(mem_lo)) else $error("indirect data not low byte");
    AST_STORAGE_REGION: assert property (o_fetch_invalid |->
        o_fetch_region == 2'h2) else $error("invalid fetch outside storage area");
    AST_PART_ID: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 16'h8006 |->
        o_reg_rdata[13:0] == {pmm_pkg::PART_RSVD, PART_ID}) else $error("part id wrong");
    AST_REV_ID: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 16'h8005 |->
        o_reg_rdata[13:0] == {pmm_pkg::REV_RSVD, MAJOR_REV, MINOR_REV}) else $error("rev wrong");
    AST_NVM_ANSWER: assert property (i_nvm_wr |=>
        o_nvm_wr_ok || o_write_error_flag) else $error("nvm write unanswered");
endmodule
bind pmm_map pmm_map_monitor #(.PART_ID(PART_ID), .MAJOR_REV(MAJOR_REV),
    .MINOR_REV(MINOR_REV), .LARGE_MEM(LARGE_MEM)) u_mon (.*);

// file: test/pmm_mem_model.sv
// Partner model: program flash array answering the indirect read address
`timescale 1ns/1ps
module pmm_mem_model (
    input wire logic [pmm_pkg::PC_W-1:0] i_addr,
    output logic [pmm_pkg::WORD_W-1:0] o_word
);
    // Contents follow the address so neighbours differ; no write path exists
    assign o_word = i_addr[13:0] ^ 14'h2C5A;
endmodule

// file: test/pmm_map_tb_top.sv
// Testbench: scenario tasks for the program memory map partition block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module pmm_map_tb_top;
    logic i_clk_sys, i_reset, i_reg_wr, i_reg_rd, i_fetch_req, i_take_reset, i_take_int;
    logic i_indirect_move_read, i_indirect_write, i_nvm_wr, o_fetch_invalid, o_ind_valid;
    logic o_ind_busy, o_nvm_wr_ok, o_write_error_flag, v;
    logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
    logic [14:0] i_fetch_pc, o_fetch_addr, o_mem_addr, i_nvm_addr;
    logic [1:0] o_fetch_region;
    logic [7:0] i_pointer_high_byte, i_pointer_low_byte, o_indirect_data_port, b;
    logic [13:0] i_mem_rdata;
    int mismatches = 0;
    int n_compared = 0;
    pmm_map #(.PART_ID(12'h5A3), .MAJOR_REV(6'h2B), .MINOR_REV(6'h15), .LARGE_MEM(1'b1)) uut (.*);
    pmm_mem_model u_mem (.i_addr(o_mem_addr), .o_word(i_mem_rdata));
    // ************************************************************
    // Bus and port tasks
    // ************************************************************
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] w);
        @(posedge i_clk_sys);
        {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, w, 1'b1};
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a, output logic [15:0] r);
        @(posedge i_clk_sys);
        {i_reg_addr, i_reg_rd} <= {a, 1'b1};
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1 r = o_reg_rdata;
    endtask
    task automatic fchk(input logic [14:0] pc, input logic [1:0] vc, input logic [14:0] ea,
        input logic [1:0] er, input logic ei);
        @(posedge i_clk_sys);
        {i_fetch_pc, i_take_int, i_take_reset} <= {pc, vc};
        @(posedge i_clk_sys);
        #1;
        `CHK("fetch_addr", ea, o_fetch_addr)
        `CHK("fetch_region", er, o_fetch_region)
        `CHK("fetch_invalid", ei, o_fetch_invalid)
    endtask
    task automatic ind_rd(input logic [7:0] hi, input logic [7:0] lo, input logic wr);
        @(posedge i_clk_sys);
        {i_pointer_high_byte, i_pointer_low_byte, i_indirect_move_read, i_indirect_write}
            <= {hi, lo, 1'b1, wr};
        @(posedge i_clk_sys);
        {i_indirect_move_read, i_indirect_write} <= 2'h0;
        @(posedge i_clk_sys);
        #1 {v, b} = {o_ind_valid, o_indirect_data_port};
    endtask
    task automatic nvm(input logic [14:0] a);
        @(posedge i_clk_sys);
        {i_nvm_addr, i_nvm_wr} <= {a, 1'b1};
        @(posedge i_clk_sys);
        i_nvm_wr <= 1'b0;
        #1;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_ids();
        reg_rd(pmm_pkg::ADDR_PART_ID, d);
        `CHK("part_id", 14'h35A3, d[13:0])
        reg_rd(pmm_pkg::ADDR_REVISION, d);
        `CHK("revision", 14'h2AD5, d[13:0])
        reg_rd(16'h8007, d);
        `CHK("unmapped", 16'h0000, d)
        reg_wr(pmm_pkg::ADDR_PART_ID, 16'h0000);
        reg_rd(pmm_pkg::ADDR_PART_ID, d);
        `CHK("part_id_ro", 14'h35A3, d[13:0])
    endtask
    task automatic t_part();
        fchk(15'h7ABC, 2'h0, 15'h1ABC, 2'h0, 1'b0);
        fchk(15'h0123, 2'h1, 15'h0000, 2'h0, 1'b0);
        fchk(15'h0123, 2'h2, 15'h0004, 2'h0, 1'b0);
        reg_wr(pmm_pkg::ADDR_CONFIG, 16'h0998);
        reg_wr(pmm_pkg::ADDR_CONFIG, 16'h0980);
        fchk(15'h0FFF, 2'h0, 15'h0FFF, 2'h1, 1'b0);
        fchk(15'h1000, 2'h0, 15'h1000, 2'h0, 1'b0);
        fchk(15'h1F7F, 2'h0, 15'h1F7F, 2'h0, 1'b0);
        fchk(15'h3F80, 2'h0, 15'h1F80, 2'h2, 1'b1);
        // Size change must bounce off while the boot block is on
        reg_wr(pmm_pkg::ADDR_CONFIG, 16'h0987);
        fchk(15'h0FFF, 2'h0, 15'h0FFF, 2'h1, 1'b0);
    endtask
    task automatic t_ind();
        ind_rd(8'hFF, 8'h12, 1'b1);
        `CHK("ind_valid", 1'b1, v)
        `CHK("ind_data", 8'h48, b)
        ind_rd(8'h9F, 8'hFF, 1'b0);
        `CHK("storage_data", 8'hA5, b)
        ind_rd(8'h1F, 8'hFF, 1'b0);
        `CHK("data_ptr", 1'b0, v)
    endtask
    task automatic t_nvm();
        reg_wr(pmm_pkg::ADDR_CONFIG, 16'h0900);
        nvm(15'h1000);
        `CHK("wr_error", 1'b1, o_write_error_flag)
        `CHK("wr_ok_prot", 1'b0, o_nvm_wr_ok)
        reg_wr(pmm_pkg::ADDR_STATUS, 16'h0001);
        nvm(15'h0100);
        `CHK("wr_ok", 1'b1, o_nvm_wr_ok)
        `CHK("wr_error_clr", 1'b0, o_write_error_flag)
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial
    begin
        i_reset = 1'b1;
        i_fetch_req = 1'b1;
        {i_reg_wr, i_reg_rd, i_take_reset, i_take_int, i_indirect_move_read} = '0;
        {i_indirect_write, i_nvm_wr, i_reg_addr, i_reg_wdata, i_fetch_pc} = '0;
        {i_pointer_high_byte, i_pointer_low_byte, i_nvm_addr} = '0;
        repeat (4) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        t_ids();
        t_part();
        t_ind();
        t_nvm();
        give_verdict();
    end
    // Whole run is about fifty cycles; this cuts a hang
    initial
    begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule
